/* File: core/cpw_cfg.svh */
`ifndef CPW_CFG_SVH
`define CPW_CFG_SVH

// ------------------------------------------------------------
// timebase
// ------------------------------------------------------------
`define CPW_CLK_MHZ 50
`define CPW_SW_KHZ 100
`define CPW_PERIOD_CYC (`CPW_CLK_MHZ * 1000 / `CPW_SW_KHZ)
`define CPW_JIT_PCT 4
`define CPW_JIT_SPAN_CYC (`CPW_PERIOD_CYC * `CPW_JIT_PCT / 100)
`define CPW_JIT_PERIOD_MS 4
`define CPW_JIT_PERIOD_CYC (`CPW_JIT_PERIOD_MS * 1000 * `CPW_CLK_MHZ)
`define CPW_DMAX_NUM 3
`define CPW_DMAX_DEN 4

// ------------------------------------------------------------
// pulse timing, least times rounded up
// ------------------------------------------------------------
`define CPW_GATE_HOLD_NS 156
`define CPW_GATE_HOLD_CYC ((`CPW_GATE_HOLD_NS * `CPW_CLK_MHZ + 999) / 1000)
`define CPW_LEB_NORM_NS 220
`define CPW_LEB_NORM_CYC ((`CPW_LEB_NORM_NS * `CPW_CLK_MHZ + 999) / 1000)
`define CPW_LEB_BURST_NS 180
`define CPW_LEB_BURST_CYC ((`CPW_LEB_BURST_NS * `CPW_CLK_MHZ + 999) / 1000)

// ------------------------------------------------------------
// sense path scaling, codes are millivolts
// ------------------------------------------------------------
`define CPW_GAIN_X4 13
`define CPW_GAIN_SHIFT 2
`define CPW_SLOPE_MV_PER_US 50
`define CPW_SLOPE_MV_PER_CYC (`CPW_SLOPE_MV_PER_US / `CPW_CLK_MHZ)
`define CPW_LL_RAMP_MV_PER_CYC 2

// ------------------------------------------------------------
// soft start
// ------------------------------------------------------------
`define CPW_SS_STEPS 32
`define CPW_SS_STEP_US 300
`define CPW_SS_STEP_CYC (`CPW_SS_STEP_US * `CPW_CLK_MHZ)
`define CPW_SS_TIME_MS 10
`define CPW_SS_TIME_CYC (`CPW_SS_TIME_MS * 1000 * `CPW_CLK_MHZ)
`define CPW_SS_LEVEL_STEP_MV 128
`define CPW_SYNC_BITS 5

`endif

/* File: core/cpw_pkg.sv */
package cpw_pkg;
    // soft start sequencing
    typedef enum logic [1:0] {
        SS_IDLE,
        SS_RAMP,
        SS_DONE
    } cpw_ss_state_t;
endpackage

/* File: core/cpw_osc.sv */
`include "cpw_cfg.svh"

// fixed-frequency oscillator with triangular period dither
module cpw_osc
    import cpw_pkg::*;
#(
    parameter int unsigned JITTER_CYCLES = `CPW_JIT_PERIOD_CYC
) (
    input wire logic ref_clk, // timebase
    input wire logic rst, // async reset, high
    input wire logic jitter_en, // dither allowed
    output logic cycle_start, // one-cycle pulse at period start
    output logic on_phase // high in the duty-limit on phase
);
    // four sweeps of the span make one dither period
    localparam int unsigned STEP_CYC = JITTER_CYCLES / (4 * `CPW_JIT_SPAN_CYC);
    localparam logic [9:0] BASE = 10'(`CPW_PERIOD_CYC);
    localparam logic [9:0] SPAN = 10'(`CPW_JIT_SPAN_CYC);

    logic [9:0] phase_reg; // position in period
    logic [9:0] offset_reg; // dither offset, two's complement
    logic up_reg; // dither direction
    logic [19:0] step_reg; // dither step timer
    logic [9:0] period; // current period length
    logic [11:0] on_len; // on-phase length

    assign period = BASE + offset_reg;
    assign on_len = 12'({2'b00, period} * 12'(`CPW_DMAX_NUM) / 12'(`CPW_DMAX_DEN));

    // ------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 10'h000;
            cycle_start <= 1'b0;
            on_phase <= 1'b0;
        end else begin
            cycle_start <= (phase_reg == 10'h000); // RL12
            on_phase <= ({2'b00, phase_reg} < on_len); // RL13
            phase_reg <= (phase_reg >= period - 10'h001) ? 10'h000 : phase_reg + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // dither sweep, parked at nominal until enabled
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            offset_reg <= 10'h000;
            up_reg <= 1'b1;
            step_reg <= 20'h00000;
        end else if (!jitter_en) begin
            offset_reg <= 10'h000; // RL14
            up_reg <= 1'b1;
            step_reg <= 20'h00000;
        end else if (step_reg >= 20'(STEP_CYC - 1)) begin
            step_reg <= 20'h00000;
            if (up_reg) begin
                offset_reg <= offset_reg + 10'h001; // RL12
                up_reg <= (offset_reg + 10'h001 != SPAN);
            end else begin
                offset_reg <= offset_reg - 10'h001;
                up_reg <= (offset_reg - 10'h001 == 10'h000 - SPAN);
            end
        end else begin
            step_reg <= step_reg + 20'h00001;
        end
    end
endmodule

/* File: core/cpw_softstart.sv */
`include "cpw_cfg.svh"

// counter-driven soft-start sequencer
module cpw_softstart
    import cpw_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `CPW_SS_STEP_CYC,
    parameter int unsigned TOTAL_CYCLES = `CPW_SS_TIME_CYC
) (
    input wire logic ref_clk, // timebase
    input wire logic rst, // async reset, high
    input wire logic start, // one-cycle start or restart request
    input wire logic clear, // undervoltage, forces step zero
    output logic [4:0] step, // current soft-start step
    output logic sink_on, // current sink active
    output logic done // soft start over
);
    cpw_ss_state_t state_reg; // sequencer state
    logic [19:0] tick_reg; // step timer
    logic [19:0] total_reg; // overall timer

    // ------------------------------------------------------------
    // sequencer, clear wins over start
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= SS_IDLE;
            tick_reg <= 20'h00000;
            total_reg <= 20'h00000;
            step <= 5'h00;
        end else if (clear) begin
            state_reg <= SS_IDLE; // RL20
            tick_reg <= 20'h00000;
            total_reg <= 20'h00000;
            step <= 5'h00;
        end else if (start) begin
            state_reg <= SS_RAMP; // RL7 RL11
            tick_reg <= 20'h00000;
            total_reg <= 20'h00000;
            step <= 5'h00;
        end else begin
            case (state_reg)
                SS_RAMP: begin
                    total_reg <= total_reg + 20'h00001;
                    if (total_reg >= 20'(TOTAL_CYCLES - 1)) begin
                        state_reg <= SS_DONE; // RL9
                    end
                    if (tick_reg >= 20'(STEP_CYCLES - 1)) begin
                        tick_reg <= 20'h00000;
                        // saturate at the last of the steps
                        if (step != 5'(`CPW_SS_STEPS - 1)) begin
                            step <= step + 5'h01; // RL8
                        end
                    end else begin
                        tick_reg <= tick_reg + 20'h00001;
                    end
                end
                SS_IDLE, SS_DONE: begin
                    tick_reg <= 20'h00000;
                end
                default: begin
                    state_reg <= SS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registered status
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sink_on <= 1'b0;
            done <= 1'b0;
        end else begin
            sink_on <= (state_reg == SS_RAMP); // RL9
            done <= (state_reg == SS_DONE);
        end
    end
endmodule

/* File: core/cpw_top.sv */
`include "cpw_cfg.svh"

// Notes on behaviour
// RL1: width trip when amplified sense exceeds feedback
// RL2: ramp switch closed in off phase
// RL3: gate held off 156ns after start
// RL4: blanked sense scaled by gain 3.25
// RL5: slope ramp 50mV/us while gate on
// RL6: no slope ramp during burst mode
// RL7: soft start begins at turn-on, 32 steps
// RL8: soft-start step advances every 300us
// RL9: soft start ends at 10ms, sink off
// RL10: duty grows from zero during soft start
// RL11: soft start rerun on each restart attempt
// RL12: 100kHz oscillator, 4% dither, 4ms sweep
// RL13: duty capped at 0.75 of period
// RL14: dither only after soft start ends
// RL15: oscillator sets latch, comparators clear it
// RL16: gate low while supply undervoltage
// RL17: peak limit clears latch every cycle
// RL18: burst limit active only in burst
// RL19: blanking 220ns normal, 180ns burst
// RL20: undervoltage resets soft-start counter
// RL21: comparator outcomes synchronised before use
module cpw_top
    import cpw_pkg::*;
#(
    parameter int unsigned SS_STEP_CYCLES = `CPW_SS_STEP_CYC,
    parameter int unsigned SS_TOTAL_CYCLES = `CPW_SS_TIME_CYC,
    parameter int unsigned JITTER_CYCLES = `CPW_JIT_PERIOD_CYC
) (
    input wire logic ref_clk, // 50 MHz timebase
    input wire logic rst, // async reset, high
    input wire logic supply_on, // supply above turn-on level
    input wire logic supply_uv, // supply below undervoltage_off_level
    input wire logic restart_req, // auto-restart attempt, level
    input wire logic burst_mode, // active burst mode entered
    input wire logic peak_cmp, // peak_limit_comparator outcome
    input wire logic burst_cmp, // burst_limit_comparator outcome
    input wire logic [9:0] sense_code, // current-sense level, mV
    input wire logic [11:0] feedback_level, // feedback level, mV
    output logic gate_drive, // power switch gate
    output logic ramp_switch, // high while ramp_switch is closed
    output logic ss_sink_on, // soft-start current sink on
    output logic [4:0] ss_step, // soft-start step
    output logic jitter_active // frequency dither running
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [`CPW_SYNC_BITS-1:0] raw_in; // asynchronous outcomes
    logic [`CPW_SYNC_BITS-1:0] meta_reg; // first stage, read by second only
    logic [`CPW_SYNC_BITS-1:0] sync_reg; // second stage, safe to use
    logic peak_s; // synchronised peak limit
    logic burst_cmp_s; // synchronised burst limit
    logic on_s; // synchronised turn-on
    logic uv_s; // synchronised undervoltage
    logic burst_s; // synchronised burst mode

    assign raw_in = {burst_mode, supply_uv, supply_on, burst_cmp, peak_cmp};

    generate
        for (genvar i = 0; i < `CPW_SYNC_BITS; i++) begin : g_sync
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= raw_in[i]; // RL21
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign peak_s = sync_reg[0];
    assign burst_cmp_s = sync_reg[1];
    assign on_s = sync_reg[2];
    assign uv_s = sync_reg[3];
    assign burst_s = sync_reg[4];

    // ------------------------------------------------------------
    // run control and start events
    // ------------------------------------------------------------
    logic run_reg; // controller biased and switching allowed
    logic on_d_reg; // previous turn-on level
    logic restart_d_reg; // previous restart level, unsynchronised
    logic restart_s_reg; // restart level, resampled
    logic ss_start; // soft-start start pulse

    // restart is treated as synchronous, one stage is enough for edges
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            on_d_reg <= 1'b0;
            restart_s_reg <= 1'b0;
            restart_d_reg <= 1'b0;
        end else begin
            on_d_reg <= on_s;
            restart_s_reg <= restart_req;
            restart_d_reg <= restart_s_reg;
        end
    end

    assign ss_start = (on_s && !on_d_reg) || (restart_s_reg && !restart_d_reg);

    // run once turned on, stop on undervoltage; uv wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_reg <= 1'b0;
        end else if (uv_s) begin
            run_reg <= 1'b0; // RL16
        end else if (ss_start) begin
            run_reg <= 1'b1; // RL7
        end
    end

    // ------------------------------------------------------------
    // oscillator and soft start
    // ------------------------------------------------------------
    logic cycle_start; // period start pulse
    logic on_phase; // duty-limit on phase
    logic ss_done; // soft start finished

    cpw_osc #(
        .JITTER_CYCLES(JITTER_CYCLES)
    ) u_osc (
        .ref_clk(ref_clk),
        .rst(rst),
        .jitter_en(jitter_active),
        .cycle_start(cycle_start),
        .on_phase(on_phase)
    );

    cpw_softstart #(
        .STEP_CYCLES(SS_STEP_CYCLES),
        .TOTAL_CYCLES(SS_TOTAL_CYCLES)
    ) u_ss (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(ss_start && !uv_s), // RL11
        .clear(uv_s), // RL20
        .step(ss_step),
        .sink_on(ss_sink_on),
        .done(ss_done)
    );

    // dither follows the end of soft start while running
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            jitter_active <= 1'b0;
        end else begin
            jitter_active <= ss_done && run_reg; // RL14
        end
    end

    // ------------------------------------------------------------
    // ramps: light-load ramp and slope compensation
    // ------------------------------------------------------------
    logic [11:0] ll_ramp_reg; // light-load voltage ramp, mV
    logic [11:0] slope_reg; // slope_compensation_ramp, mV

    // ramp_switch discharges the ramp in the off phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ramp_switch <= 1'b1;
            ll_ramp_reg <= 12'h000;
        end else begin
            ramp_switch <= !on_phase || cycle_start; // RL2
            if (ramp_switch) begin
                ll_ramp_reg <= 12'h000;
            end else if (ll_ramp_reg < 12'hf00) begin
                ll_ramp_reg <= ll_ramp_reg + 12'(`CPW_LL_RAMP_MV_PER_CYC);
            end
        end
    end

    // slope rises only with the gate on, never in burst
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slope_reg <= 12'h000;
        end else if (burst_s || !gate_drive) begin
            slope_reg <= 12'h000; // RL6
        end else if (slope_reg < 12'hf00) begin
            slope_reg <= slope_reg + 12'(`CPW_SLOPE_MV_PER_CYC); // RL5
        end
    end

    // ------------------------------------------------------------
    // start hold and leading-edge blanking
    // ------------------------------------------------------------
    logic [3:0] hold_reg; // cycles since period start
    logic hold_done; // start hold elapsed
    logic [3:0] blank_reg; // cycles since gate turn-on
    logic [3:0] blank_len; // blanking length for the mode
    logic blank_done; // blanking_window elapsed

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_reg <= 4'h0;
        end else if (cycle_start) begin
            hold_reg <= 4'h0;
        end else if (!hold_done) begin
            hold_reg <= hold_reg + 4'h1; // RL3
        end
    end

    assign hold_done = (hold_reg >= 4'(`CPW_GATE_HOLD_CYC - 1));

    // shorter window in burst since spikes are smaller
    assign blank_len = burst_s ? 4'(`CPW_LEB_BURST_CYC) : 4'(`CPW_LEB_NORM_CYC); // RL19

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            blank_reg <= 4'h0;
        end else if (!gate_drive) begin
            blank_reg <= 4'h0;
        end else if (!blank_done) begin
            blank_reg <= blank_reg + 4'h1;
        end
    end

    assign blank_done = gate_drive && (blank_reg >= blank_len); // RL19

    // ------------------------------------------------------------
    // sense amplifier and comparators
    // ------------------------------------------------------------
    logic [13:0] amp_sense; // blanked sense times 3.25
    logic [13:0] ramp_sum; // amplified sense plus ramps
    logic [12:0] ss_level; // ramp_up_level, mV
    logic width_trip; // width_comparator
    logic ss_trip; // soft-start comparator
    logic limit_trip; // peak or burst limit
    logic terminate; // any comparator trip clearing pulse_latch

    // sense path is forced to zero inside the blanking window
    assign amp_sense = blank_done ?
        14'(({4'h0, sense_code} * 14'(`CPW_GAIN_X4)) >> `CPW_GAIN_SHIFT) : 14'h0000; // RL4
    assign ramp_sum = amp_sense + {2'b00, ll_ramp_reg} + {2'b00, slope_reg}; // RL5
    assign ss_level = 13'(({8'h00, ss_step} + 13'h0001) * 13'(`CPW_SS_LEVEL_STEP_MV));

    assign width_trip = ramp_sum > {2'b00, feedback_level}; // RL1
    // limit stays in the loop only while the sink is active
    assign ss_trip = ss_sink_on && (ramp_sum > {1'b0, ss_level}); // RL10
    assign limit_trip = peak_s || (burst_s && burst_cmp_s); // RL17 RL18
    assign terminate = blank_done && (width_trip || ss_trip || limit_trip); // RL15

    // ------------------------------------------------------------
    // pulse latch and gate
    // ------------------------------------------------------------
    logic latch_reg; // pulse_latch
    logic gate_next; // next gate level

    // set by the oscillator, cleared by a trip or by the off phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_reg <= 1'b0;
        end else if (uv_s || !run_reg) begin
            latch_reg <= 1'b0; // RL16
        end else if (cycle_start) begin
            latch_reg <= 1'b1; // RL15
        end else if (terminate || !on_phase) begin
            latch_reg <= 1'b0; // RL1 RL17 RL13
        end
    end

    // trip term bypasses the latch so the gate drops on the next edge
    assign gate_next = latch_reg && !terminate && hold_done && on_phase && run_reg && !uv_s;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gate_drive <= 1'b0;
        end else begin
            gate_drive <= gate_next; // RL3 RL15
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence gate_rise_s;
        $rose(gate_drive);
    endsequence

    sequence trip_s;
        gate_drive && terminate;
    endsequence

    width_trip_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
        gate_drive && blank_done && width_trip |=> !gate_drive)
        else $error("gate stayed on after width trip");

    ramp_release_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
        gate_rise_s |-> !ramp_switch)
        else $error("ramp switch closed while gate pulse starts");

    start_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RL3
        cycle_start |-> !gate_drive [*8])
        else $error("gate on inside the start hold");

    slope_rise_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
        gate_drive && !burst_s && $past(gate_drive) && !$past(burst_s)
            && $past(slope_reg) < 12'h0f0 |-> slope_reg == $past(slope_reg) + 12'h001)
        else $error("slope ramp not rising by one step");

    burst_slope_a: assert property (@(posedge ref_clk) disable iff (rst) // RL6
        burst_s ##1 burst_s |-> slope_reg == 12'h000)
        else $error("slope ramp present in burst");

    ss_level_a: assert property (@(posedge ref_clk) disable iff (rst) // RL10
        gate_drive && blank_done && ss_sink_on && ramp_sum > {1'b0, ss_level} |=> !gate_drive)
        else $error("soft-start limit ignored");

    jitter_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RL14
        !ss_done |=> !jitter_active)
        else $error("dither active before soft start end");

    trip_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RL15
        trip_s |=> !gate_drive && !latch_reg)
        else $error("latch survived a trip");

    uv_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // RL16
        uv_s |=> !gate_drive [*2])
        else $error("gate on under undervoltage");

    peak_limit_a: assert property (@(posedge ref_clk) disable iff (rst) // RL17
        gate_drive && blank_done && peak_s |=> !gate_drive)
        else $error("peak limit ignored");

    burst_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // RL18
        gate_drive && on_phase && run_reg && !uv_s && !burst_s && !peak_s
            && !width_trip && !ss_trip |=> gate_drive)
        else $error("burst limit acted outside burst");

    blank_window_a: assert property (@(posedge ref_clk) disable iff (rst) // RL19
        gate_rise_s |-> !blank_done [*8] ##1 !blank_done)
        else $error("sense compared inside blanking window");

    uv_step_a: assert property (@(posedge ref_clk) disable iff (rst) // RL20
        uv_s |=> ##1 ss_step == 5'h00)
        else $error("soft-start step not cleared by undervoltage");

    duty_cap_a: assert property (@(posedge ref_clk) disable iff (rst) // RL13
        gate_drive |-> $past(on_phase))
        else $error("gate on outside on phase");
endmodule

/* File: tb/cpw_sw_model.sv */
// power switch and sense resistor seen from the controller
module cpw_sw_model (
    input wire logic ref_clk, // timebase
    input wire logic gate_drive, // gate from the controller
    input wire logic [9:0] limit_mv, // peak threshold, mV
    output logic [9:0] sense_code, // sensed current, mV
    output logic peak_cmp // high above threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sense_code = 10'h000;
    // current rises 1 mV a cycle while conducting, collapses when off
    always @(posedge ref_clk) begin
        sense_code <= gate_drive ? sense_code + 10'h001 : 10'h000;
    end
    assign peak_cmp = sense_code > limit_mv;
endmodule

/* File: tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, supply_on = 1'b0, supply_uv = 1'b0, restart_req = 1'b0;
    logic burst_mode = 1'b0, burst_cmp = 1'b1; // burst limit over threshold all run long
    logic [11:0] feedback_level = 12'hfff; // wide open: no width trip
    logic [9:0] limit_mv = 10'h3ff; // partner peak threshold
    logic [9:0] sense_code;
    logic peak_cmp, gate_drive, ramp_switch, ss_sink_on, jitter_active;
    logic [4:0] ss_step;
    logic [4:0] mon; // watched bits, picked by index
    int errors = 0, tests_run = 0, cyc = 0, n;
    assign mon = {ss_step[0], peak_cmp, ss_sink_on, ramp_switch, gate_drive};
    // short counts keep the run brief
    cpw_top #(.SS_STEP_CYCLES(20), .SS_TOTAL_CYCLES(700), .JITTER_CYCLES(1600)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .supply_on(supply_on), .supply_uv(supply_uv),
        .restart_req(restart_req), .burst_mode(burst_mode), .peak_cmp(peak_cmp),
        .burst_cmp(burst_cmp),
        .sense_code(sense_code), .feedback_level(feedback_level), .gate_drive(gate_drive),
        .ramp_switch(ramp_switch), .ss_sink_on(ss_sink_on), .ss_step(ss_step),
        .jitter_active(jitter_active));
    cpw_sw_model sw_u (.ref_clk(ref_clk), .gate_drive(gate_drive), .limit_mv(limit_mv),
        .sense_code(sense_code), .peak_cmp(peak_cmp));
    initial forever #10 ref_clk = ~ref_clk;
    // hang guard, well above the few thousand cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // sample on the falling edge so registered outputs have settled
    task automatic wait_for(input int s, input logic lvl, output int k);
        k = 0;
        while (mon[s] !== lvl && k < 2000) begin
            @(negedge ref_clk);
            k++;
        end
    endtask
    task automatic t_softstart();
        @(posedge ref_clk) supply_on <= 1'b1;
        wait_for(2, 1'b1, n);
        check(12'(n <= 8), 12'h001);
        check(12'(jitter_active), 12'h000);
        wait_for(4, 1'b1, n);
        wait_for(4, 1'b0, n);
        check(12'(n), 12'd20);
        wait_for(2, 1'b0, n);
        check(12'(ss_step), 12'd31);
        repeat (3) @(negedge ref_clk);
        check(12'(jitter_active), 12'h001);
    endtask
    task automatic t_gate();
        // align to a fresh period: off phase first, then the ramp release
        wait_for(1, 1'b1, n);
        wait_for(1, 1'b0, n);
        wait_for(0, 1'b1, n);
        check(12'(n >= 7), 12'h001);
        wait_for(0, 1'b0, n);
        check(12'(n <= 390 && n >= 300), 12'h001);
        repeat (2) @(negedge ref_clk);
        check(12'(ramp_switch), 12'h001);
    endtask
    task automatic t_trip();
        @(posedge ref_clk) limit_mv <= 10'h028;
        wait_for(0, 1'b1, n);
        wait_for(3, 1'b1, n);
        wait_for(0, 1'b0, n);
        check(12'(n <= 3), 12'h001);
        @(posedge ref_clk) limit_mv <= 10'h3ff;
        feedback_level <= 12'h0c8;
        wait_for(0, 1'b0, n);
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
        check(12'(n >= 11 && n <= 40), 12'h001);
    endtask
    // burst limit cuts the pulse right at the shorter blanking end
    task automatic t_burst();
        @(posedge ref_clk) burst_mode <= 1'b1;
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
        check(12'(n), 12'd10);
        @(posedge ref_clk) burst_mode <= 1'b0;
    endtask
    task automatic t_uv();
        @(posedge ref_clk) supply_uv <= 1'b1;
        repeat (6) @(negedge ref_clk);
        check(12'({gate_drive, ss_sink_on}), 12'h000);
        check(12'(ss_step), 12'h000);
        @(posedge ref_clk) supply_uv <= 1'b0;
        repeat (4) @(posedge ref_clk);
        restart_req <= 1'b1;
        wait_for(2, 1'b1, n);
        check(12'(n <= 8), 12'h001);
        check(12'(ss_step), 12'h000);
    endtask
    task automatic print_verdict();
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check(12'({gate_drive, ramp_switch, ss_sink_on, jitter_active}), 12'h004);
        check(12'(ss_step), 12'h000);
        t_softstart();
        t_gate();
        t_trip();
        t_burst();
        t_uv();
        print_verdict();
    end
endmodule
